//--- dv/arpt_host_model.sv
// Purpose: Host model that drives the plain register port of the reset phase timer.
// Assumes: Strobes last one cycle and change just after a rising edge.
// Notes: Idle write data is inverted, so a stale word never looks like a live one.
`timescale 1ns/1ns
module arpt_host_model (
  input wire logic clk_sys_i,
  input wire logic [23:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [23:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 24'h000000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  task automatic write_reg(input logic [7:0] addr, input logic [23:0] data);
    @(posedge clk_sys_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~data;
  endtask : write_reg

  // The read word stands only in the cycle after the strobe, so it is taken there.
  task automatic read_reg(input logic [7:0] addr, output logic [23:0] data);
    @(posedge clk_sys_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1;
    data = reg_rdata_i;
  endtask : read_reg
endmodule : arpt_host_model

//--- dv/testbench.sv
// Purpose: Self-checking bench for the reset phase timer.
// Assumes: Enable lives at offset 1E bit 8; phases trail the count by one clock.
// Notes: Terminal count is kept small so several periods fit in a short run.
`timescale 1ns/1ns
module testbench;
  logic clk_sys_i, rst_n_i, reg_wr, reg_rd, wrap, enable;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, rdat, wv;
  logic [15:0] count, term, exp_cnt, prev_cnt;
  logic [3:0] phase, ph;
  logic [15:0] win_b [4];
  logic [15:0] win_f [4];
  int err_count = 0;
  int cmp_count = 0;
  int n;

  arpt_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .count_o(count), .period_wrap_o(wrap), .adc_reset_phase_o(phase),
    .timing_engine_enable_o(enable));
  arpt_host_model u_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ********************************************************
  // Checking helpers
  // ********************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic in_win(input logic [15:0] c, input logic [15:0] b,
                                  input logic [15:0] f);
    return (c >= b) && (c <= f);
  endfunction : in_win

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst_n_i = 1'b0;
    void'($urandom(32'h7E9C21E1));
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 8'h15; a <= 8'h1F; a++) begin
      u_host.read_reg(a[7:0], rdat);
      check(rdat, 24'h000000, "reset value");
    end
    $display("test reset values done");
    for (int a = 8'h15; a <= 8'h1D; a++) begin
      wv = 24'($urandom());
      u_host.write_reg(a[7:0], wv);
      u_host.read_reg(a[7:0], rdat);
      check(rdat, {8'h00, wv[15:0]}, "read back");
    end
    u_host.write_reg(8'h40, 24'hFFFFFF);
    u_host.read_reg(8'h40, rdat);
    check(rdat, 24'h000000, "unmapped read");
    $display("test register access done");
    term = 16'(8 + $urandom_range(8));
    win_b = '{16'h0000, term, 16'h0005, 16'(1 + $urandom_range(3))};
    win_f = '{term, term, 16'h0002, 16'(4 + $urandom_range(3))};
    for (int p = 0; p < 4; p++) begin
      u_host.write_reg(8'(8'h15 + 2 * p), {8'hA5, win_b[p]});
      u_host.write_reg(8'(8'h16 + 2 * p), {8'h5A, win_f[p]});
    end
    u_host.write_reg(8'h1D, {8'h00, term});
    u_host.write_reg(8'h1E, 24'h000100);
    #1;
    n = 0;
    while (count === 16'h0000 && n < 10) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n == 10) begin
      err_count++;
      $display("unexpected at %0t: counter never started", $time);
      give_verdict();
    end
    exp_cnt = 16'h0001;
    prev_cnt = 16'h0000;
    for (int i = 0; i < 3 * (term + 1); i++) begin
      check(24'(count), 24'(exp_cnt), "count");
      check(24'(wrap), 24'(exp_cnt == term), "wrap");
      check(24'(enable), 24'h000001, "enable");
      for (int p = 0; p < 4; p++) ph[p] = in_win(prev_cnt, win_b[p], win_f[p]);
      check(24'(phase), 24'(ph), "phases");
      prev_cnt = exp_cnt;
      exp_cnt = (exp_cnt == term) ? 16'h0000 : exp_cnt + 16'h0001;
      @(posedge clk_sys_i);
      #1;
    end
    u_host.read_reg(8'h1E, rdat);
    check(rdat, 24'h000100, "enable read back");
    $display("test counting and phases done");
    u_host.write_reg(8'h1E, 24'hFFFEFF);
    repeat (3) @(posedge clk_sys_i);
    #1;
    check(24'(count), 24'h000000, "count off");
    check(24'(phase), 24'h000000, "phases off");
    check(24'(enable), 24'h000000, "enable off");
    $display("test disable done");
    u_host.write_reg(8'h1E, 24'h000100);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    check(24'(count), 24'h000000, "count after reset");
    check(24'(enable), 24'h000000, "enable after reset");
    u_host.read_reg(8'h1D, rdat);
    check(rdat, 24'h000000, "terminal after reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : testbench

//--- logic/arpt_consts.svh
`ifndef ARPT_CONSTS_SVH
`define ARPT_CONSTS_SVH
// Purpose: Offsets, field positions and reset values of the reset phase timer.
// Assumes: Register index equals the byte address on the plain register port.
// Notes: The enable register offset is a local choice.
`define ARPT_ADDR_W 8
`define ARPT_DATA_W 24
`define ARPT_FIELD_W 16
`define ARPT_OFF_P0_BEGIN 8'h15
`define ARPT_OFF_P0_FINISH 8'h16
`define ARPT_OFF_P1_BEGIN 8'h17
`define ARPT_OFF_P1_FINISH 8'h18
`define ARPT_OFF_P2_BEGIN 8'h19
`define ARPT_OFF_P2_FINISH 8'h1A
`define ARPT_OFF_P3_BEGIN 8'h1B
`define ARPT_OFF_P3_FINISH 8'h1C
`define ARPT_OFF_TERMINAL 8'h1D
`define ARPT_OFF_ENABLE 8'h1E
`define ARPT_ENABLE_BIT 8
`define ARPT_FIELD_RESET 16'h0000
`define ARPT_NUM_PHASES 4
`endif

//--- logic/arpt_counter.sv
// Purpose: Free repetition counter that wraps at a terminal value.
// Assumes: Synchronous active-low reset.
// Notes: Held at zero while disabled.
`timescale 1ns/1ns
module arpt_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] terminal_i,
  output logic [WIDTH-1:0] count_o,
  output logic wrap_o
);
  logic [WIDTH-1:0] count_reg;

  assign wrap_o = run_i && (count_reg >= terminal_i);
  assign count_o = count_reg;

  // A terminal lowered below the count still wraps at once, no overrun.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run_i) begin
      count_reg <= '0;
    end else if (wrap_o) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  chk_wrap_to_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wrap_o |=> count_reg == '0) else $error("counter did not wrap");
  chk_count_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (run_i && !wrap_o) ##1 run_i |-> count_reg == $past(count_reg) + 1'b1)
    else $error("counter did not step");
endmodule : arpt_counter

//--- logic/arpt_pkg.sv
// Purpose: Types shared by the reset phase timer files.
// Assumes: Constants come from arpt_consts.svh.
// Notes: None.
package arpt_pkg;
  typedef struct packed {
    logic [15:0] begin_cnt;
    logic [15:0] finish_cnt;
  } arpt_window_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } arpt_bus_req_t;

  typedef enum logic {
    ARPT_IDLE,
    ARPT_RUN
  } arpt_state_t;
endpackage : arpt_pkg

//--- logic/arpt_top.sv
// Purpose: Repetition counter and four ADC reset phase windows with registers.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes: Phases trail the count by one clock.
`include "arpt_consts.svh"
`timescale 1ns/1ns
module arpt_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [23:0] reg_rdata_o,
  output logic [15:0] count_o,
  output logic period_wrap_o,
  output logic [3:0] adc_reset_phase_o,
  output logic timing_engine_enable_o
);
  // ****************************************
  // Register file
  // ****************************************
  arpt_pkg::arpt_window_t win_reg [`ARPT_NUM_PHASES];
  logic [15:0] terminal_reg;
  logic enable_reg;
  logic [23:0] rdata_reg;
  logic [23:0] rdata_next;
  arpt_pkg::arpt_state_t state_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `ARPT_NUM_PHASES; gi++) begin : g_win_regs
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          win_reg[gi].begin_cnt <= `ARPT_FIELD_RESET;
          win_reg[gi].finish_cnt <= `ARPT_FIELD_RESET;
        end else if (reg_wr_i) begin
          if (reg_addr_i == `ARPT_OFF_P0_BEGIN + 8'(2 * gi)) begin
            win_reg[gi].begin_cnt <= reg_wdata_i[15:0];
          end
          if (reg_addr_i == `ARPT_OFF_P0_FINISH + 8'(2 * gi)) begin
            win_reg[gi].finish_cnt <= reg_wdata_i[15:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      terminal_reg <= `ARPT_FIELD_RESET;
    end else if (reg_wr_i && reg_addr_i == `ARPT_OFF_TERMINAL) begin
      terminal_reg <= reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      enable_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `ARPT_OFF_ENABLE) begin
      enable_reg <= reg_wdata_i[`ARPT_ENABLE_BIT];
    end
  end

  // Unmapped addresses read as zero so software probing is harmless.
  always_comb begin
    rdata_next = 24'h000000;
    case (reg_addr_i)
      `ARPT_OFF_P0_BEGIN: rdata_next = {8'h00, win_reg[0].begin_cnt};
      `ARPT_OFF_P0_FINISH: rdata_next = {8'h00, win_reg[0].finish_cnt};
      `ARPT_OFF_P1_BEGIN: rdata_next = {8'h00, win_reg[1].begin_cnt};
      `ARPT_OFF_P1_FINISH: rdata_next = {8'h00, win_reg[1].finish_cnt};
      `ARPT_OFF_P2_BEGIN: rdata_next = {8'h00, win_reg[2].begin_cnt};
      `ARPT_OFF_P2_FINISH: rdata_next = {8'h00, win_reg[2].finish_cnt};
      `ARPT_OFF_P3_BEGIN: rdata_next = {8'h00, win_reg[3].begin_cnt};
      `ARPT_OFF_P3_FINISH: rdata_next = {8'h00, win_reg[3].finish_cnt};
      `ARPT_OFF_TERMINAL: rdata_next = {8'h00, terminal_reg};
      `ARPT_OFF_ENABLE: rdata_next = {15'h0000, enable_reg, 8'h00};
      default: rdata_next = 24'h000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !reg_rd_i) begin
      rdata_reg <= 24'h000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // ****************************************
  // Timing engine
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= arpt_pkg::ARPT_IDLE;
    end else begin
      case (state_reg)
        arpt_pkg::ARPT_IDLE: if (enable_reg) state_reg <= arpt_pkg::ARPT_RUN;
        arpt_pkg::ARPT_RUN: if (!enable_reg) state_reg <= arpt_pkg::ARPT_IDLE;
        default: state_reg <= arpt_pkg::ARPT_IDLE;
      endcase
    end
  end

  logic run;
  assign run = (state_reg == arpt_pkg::ARPT_RUN) && enable_reg;
  assign timing_engine_enable_o = enable_reg;

  arpt_counter #(.WIDTH(`ARPT_FIELD_W)) u_counter (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(run),
    .terminal_i(terminal_reg),
    .count_o(count_o),
    .wrap_o(period_wrap_o)
  );

  generate
    for (gi = 0; gi < `ARPT_NUM_PHASES; gi++) begin : g_phase
      arpt_window u_win (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .run_i(run),
        .count_i(count_o),
        .win_i(win_reg[gi]),
        .phase_o(adc_reset_phase_o[gi])
      );
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  // The phase checks look one cycle back because every phase output is registered.
  chk_phase_window: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 adc_reset_phase_o[0] == ($past(run) && $past(count_o) >= $past(win_reg[0].begin_cnt)
    && $past(count_o) <= $past(win_reg[0].finish_cnt)))
    else $error("phase 0 window wrong");
  chk_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !enable_reg ##1 !enable_reg |->
    count_o == 16'h0000 && adc_reset_phase_o == 4'h0)
    else $error("engine ran while disabled");
  // Software may lower the terminal at any time, so the bound is the one of the last clock.
  chk_count_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $stable(terminal_reg) && count_o <= terminal_reg |=>
    count_o <= $past(terminal_reg))
    else $error("count passed terminal");
  chk_term_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `ARPT_OFF_TERMINAL |=>
    terminal_reg == $past(reg_wdata_i[15:0]))
    else $error("terminal write lost");
  chk_read_upper: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rdata_o[23:16] == 8'h00)
    else $error("upper bits not zero");
  chk_read_term: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i && !reg_wr_i && reg_addr_i == `ARPT_OFF_TERMINAL |=>
    reg_rdata_o[15:0] == $past(terminal_reg))
    else $error("terminal readback wrong");
  chk_win_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `ARPT_OFF_P3_FINISH |=>
    win_reg[3].finish_cnt == $past(reg_wdata_i[15:0]))
    else $error("window write lost");
  chk_p0_begin: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `ARPT_OFF_P0_BEGIN |=>
    win_reg[0].begin_cnt == $past(reg_wdata_i[15:0]))
    else $error("begin write lost");
  chk_term_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(reg_wr_i && reg_addr_i == `ARPT_OFF_TERMINAL) |=>
    $stable(terminal_reg))
    else $error("terminal changed without a write");
  chk_enable_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `ARPT_OFF_ENABLE |=>
    enable_reg == $past(reg_wdata_i[`ARPT_ENABLE_BIT]))
    else $error("enable write lost");
  chk_enable_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(reg_wr_i && reg_addr_i == `ARPT_OFF_ENABLE) |=>
    $stable(enable_reg))
    else $error("enable changed without a write");
  chk_read_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == `ARPT_OFF_ENABLE |=>
    reg_rdata_o == {15'h0000, $past(enable_reg), 8'h00})
    else $error("enable readback wrong");
  chk_read_unmapped: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i && (reg_addr_i < `ARPT_OFF_P0_BEGIN || reg_addr_i > `ARPT_OFF_ENABLE) |=>
    reg_rdata_o == 24'h000000)
    else $error("unmapped read not zero");
  // Read data stand for one cycle only, so a stale word can never be taken twice.
  chk_read_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !reg_rd_i |=>
    reg_rdata_o == 24'h000000)
    else $error("read data outlived the strobe");
  // The engine needs one clock to leave idle, so the first count step comes on the second clock after enable rises.
  chk_start_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(enable_reg) |->
    !run && count_o == 16'h0000)
    else $error("engine started too early");
  chk_start_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(enable_reg) ##1 enable_reg |->
    run)
    else $error("engine did not start");
  chk_count_from_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(run) |->
    count_o == 16'h0000)
    else $error("period did not start at zero");
  chk_disable_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(enable_reg) |=>
    count_o == 16'h0000 && adc_reset_phase_o == 4'h0)
    else $error("disable did not clear the engine");
  // Reset checks carry no disable clause, since reset is exactly what they watch.
  chk_reset_regs: assert property (@(posedge clk_sys_i)
    !rst_n_i |=>
    terminal_reg == `ARPT_FIELD_RESET && enable_reg == 1'b0)
    else $error("register not cleared by reset");
  chk_reset_outputs: assert property (@(posedge clk_sys_i)
    !rst_n_i |=>
    count_o == 16'h0000 && adc_reset_phase_o == 4'h0 && reg_rdata_o == 24'h000000)
    else $error("output not cleared by reset");

  // ****************************************
  // Per-pair checks
  // ****************************************
  // Every begin/finish pair gets its own copy, so a slip in the address stride shows up
  // on the label of the pair that it hits.
  generate
    for (gi = 0; gi < `ARPT_NUM_PHASES; gi++) begin : g_win_chk
      localparam logic [7:0] BEGIN_ADDR = `ARPT_OFF_P0_BEGIN + 8'(2 * gi);
      localparam logic [7:0] FINISH_ADDR = `ARPT_OFF_P0_FINISH + 8'(2 * gi);
      chk_begin_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == BEGIN_ADDR |=>
        win_reg[gi].begin_cnt == $past(reg_wdata_i[15:0]))
        else $error("begin write lost");
      chk_finish_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == FINISH_ADDR |=>
        win_reg[gi].finish_cnt == $past(reg_wdata_i[15:0]))
        else $error("finish write lost");
      chk_begin_hold: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !(reg_wr_i && reg_addr_i == BEGIN_ADDR) |=>
        $stable(win_reg[gi].begin_cnt))
        else $error("begin changed without a write");
      chk_finish_hold: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        !(reg_wr_i && reg_addr_i == FINISH_ADDR) |=>
        $stable(win_reg[gi].finish_cnt))
        else $error("finish changed without a write");
      chk_begin_read: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == BEGIN_ADDR |=>
        reg_rdata_o == {8'h00, $past(win_reg[gi].begin_cnt)})
        else $error("begin readback wrong");
      chk_finish_read: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == FINISH_ADDR |=>
        reg_rdata_o == {8'h00, $past(win_reg[gi].finish_cnt)})
        else $error("finish readback wrong");
      chk_win_reset: assert property (@(posedge clk_sys_i)
        !rst_n_i |=>
        win_reg[gi].begin_cnt == `ARPT_FIELD_RESET
        && win_reg[gi].finish_cnt == `ARPT_FIELD_RESET)
        else $error("window not cleared by reset");
      chk_phase_tracks: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        ##1 adc_reset_phase_o[gi] == ($past(run)
        && $past(count_o) >= $past(win_reg[gi].begin_cnt)
        && $past(count_o) <= $past(win_reg[gi].finish_cnt)))
        else $error("phase window wrong");
      // A pair with begin above finish describes an empty window and must stay low.
      chk_empty_window: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i)
        $past(win_reg[gi].begin_cnt > win_reg[gi].finish_cnt) |->
        !adc_reset_phase_o[gi])
        else $error("empty window asserted");
    end
  endgenerate

  // ****************************************
  // Coverage
  // ****************************************
  cov_wrap: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) period_wrap_o);
  cov_phase0: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(adc_reset_phase_o[0]));
  cov_disable: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $fell(enable_reg));
  cov_phase1_pulse: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(adc_reset_phase_o[1]) ##1 $fell(adc_reset_phase_o[1]));
  cov_reset_running: cover property (@(posedge clk_sys_i) enable_reg && !rst_n_i);
endmodule : arpt_top

//--- logic/arpt_window.sv
// Purpose: Compares the count against one begin/finish pair.
// Assumes: Count and window values are in the same clock domain.
// Notes: Output is registered, so it trails the count by one cycle.
`timescale 1ns/1ns
module arpt_window (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [15:0] count_i,
  input arpt_pkg::arpt_window_t win_i,
  output logic phase_o
);
  logic phase_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= run_i && (count_i >= win_i.begin_cnt) &&
        (count_i <= win_i.finish_cnt);
    end
  end
  assign phase_o = phase_reg;
endmodule : arpt_window
